// ===== bench/idt_decode_top_bench.sv
// Purpose: self-checking bench for the instruction decode and timing block
// Assumes: the memory model feeds one word per instruction cycle
// Notes: each case runs a nop, the words under test, then nops
`timescale 1ns/1ps
module idt_decode_top_bench;
	localparam int BY = int'(idt_pkg::IDT_GRP_BYTE);
	localparam int BI = int'(idt_pkg::IDT_GRP_BIT);
	localparam int LI = int'(idt_pkg::IDT_GRP_LIT);
	localparam int CT = int'(idt_pkg::IDT_GRP_CTL);
	logic                 mclk_in;
	logic                 rst_in;
	logic                 load_in;
	logic [2:0]           load_addr;
	logic [17:0]          load_data;
	logic [15:0]          word;
	logic                 cond_true, pc_change;
	idt_pkg::idt_fields_t fields;
	idt_pkg::idt_move_t   move, move_seen;
	logic                 wr_working, wr_file, exec_nop, fetch_next, instr_done;
	logic [1:0]           cycles, quarter;
	int                   errors, check_count, gap, n_nop, n_wrw, n_wrf, n_mv, n_fetch;

	idt_prog_mem idt_prog_mem_inst (.mclk_in(mclk_in), .rst_in(rst_in),
		.fetch_next_in(fetch_next), .load_in(load_in), .load_addr_in(load_addr),
		.load_data_in(load_data), .word_out(word), .cond_true_out(cond_true),
		.pc_change_out(pc_change));

	idt_decode_top idt_decode_top_inst (.mclk_in(mclk_in), .rst_in(rst_in), .word_in(word),
		.cond_true_in(cond_true), .pc_change_in(pc_change), .fields_out(fields),
		.move_out(move), .wr_working_out(wr_working), .wr_file_out(wr_file),
		.exec_nop_out(exec_nop), .fetch_next_out(fetch_next), .cycles_out(cycles),
		.instr_done_out(instr_done), .quarter_out(quarter));

	always #10 mclk_in = ~mclk_in;

	task automatic step();
		@(posedge mclk_in);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// -1 marks a count the case does not judge
	task automatic run_case(input string name, input logic [15:0] w1, w2, w3,
		input logic cnd, pcc, input int grp, cyc, wrf, wrw, nop, mv);
		int t;
		rst_in = 1'h1;
		for (int i = 0; i < 8; i++) begin
			step();
			load_in = 1'h1;
			load_addr = 3'(i);
			load_data = (i == 1) ? {cnd, pcc, w1} : (i == 2) ? {2'h0, w2} :
				(i == 3) ? {2'h0, w3} : 18'h0;
		end
		step();
		load_in = 1'h0;
		chk(16'({instr_done, fetch_next}), 16'h0, "quiet in reset");
		rst_in = 1'h0;
		t = 0;
		while (instr_done !== 1'h1 && t < 20) begin
			step();
			t++;
		end
		{gap, n_nop, n_wrw, n_wrf, n_mv, n_fetch} = '0;
		move_seen = '0;
		do begin
			step();
			gap++;
			n_nop += int'(exec_nop === 1'h1);
			n_wrw += int'(wr_working === 1'h1);
			n_wrf += int'(wr_file === 1'h1);
			n_fetch += int'(fetch_next === 1'h1);
			if (move.valid === 1'h1) begin
				n_mv++;
				move_seen = move;
			end
		end while (instr_done !== 1'h1 && gap < 20);
		chk(16'(gap), 16'(4 * cyc), {name, " span"});
		chk(16'(n_fetch), 16'(cyc), {name, " fetches"});
		chk(16'(cycles), 16'(cyc), {name, " cycles"});
		if (grp >= 0) chk(16'(fields.group), 16'(grp), {name, " group"});
		if (wrf >= 0) chk(16'(n_wrf), 16'(wrf), {name, " file write"});
		if (wrw >= 0) chk(16'(n_wrw), 16'(wrw), {name, " working write"});
		if (nop >= 0) chk(16'(n_nop), 16'(nop), {name, " nop cycles"});
		if (mv >= 0) chk(16'(n_mv), 16'(mv), {name, " move"});
		$display("done %s", name);
	endtask

	initial begin
		#100000;
		errors++;
		$display("BAD %0t watchdog expired", $time);
		end_sim();
	end

	initial begin
		{mclk_in, rst_in, load_in, load_addr, load_data} = '0;
		{errors, check_count} = '0;
		rst_in = 1'h1;
		repeat (2) @(posedge mclk_in);
		#1;
		run_case("add to file", 16'h275a, 0, 0, 0, 0, BY, 1, 1, 0, 0, 0);
		chk(16'({fields.file_addr, fields.dest_file, fields.access_bank}), 16'h16b, "f d a");
		run_case("add to working", 16'h24a5, 0, 0, 0, 0, BY, 1, 0, 1, 0, 0);
		chk(16'({fields.file_addr, fields.dest_file, fields.access_bank}), 16'h294, "f d a");
		run_case("bit set", 16'h8a3c, 0, 0, 0, 0, BI, 1, -1, -1, 0, 0);
		chk(16'({fields.bit_num, fields.file_addr}), 16'h53c, "bit and file");
		run_case("bit test taken", 16'hb610, 0, 0, 1, 0, BI, 2, -1, -1, 1, 0);
		run_case("literal", 16'h0e96, 0, 0, 0, 0, LI, 1, 0, 0, 0, 0);
		chk(16'(fields.literal), 16'h96, "literal");
		run_case("pointer load", 16'hee21, 16'hf0ab, 0, 0, 0, LI, 2, 0, 0, -1, 0);
		chk(16'(fields.ptr_sel), 16'h2, "pointer select");
		run_case("branch", 16'hd123, 0, 0, 0, 1, CT, 2, 0, 0, 1, 0);
		chk(16'(fields.prog_addr), 16'h123, "program address");
		run_case("goto", 16'hef34, 16'hf012, 0, 0, 0, CT, 2, 0, 0, -1, 0);
		run_case("call taken", 16'hed34, 16'hf012, 0, 0, 1, CT, 3, 0, 0, 1, 0);
		chk(16'(fields.fast_mode), 16'h1, "call mode");
		run_case("file move", 16'hcfab, 16'hfbcd, 0, 0, 0, BY, 2, -1, -1, -1, 1);
		chk(16'(move_seen.src_addr), 16'h3ab, "move source");
		chk(16'(move_seen.dst_addr), 16'h3cd, "move destination");
		run_case("long move", 16'h0061, 16'hf012, 16'hf345, 0, 0, BY, 3, -1, -1, -1, -1);
		run_case("lone ext word", 16'hf123, 0, 0, 0, 0, -1, 1, 0, 0, 1, 0);
		chk(16'(fields.is_nop), 16'h1, "lone word nop");
		run_case("table write", 16'h000d, 0, 0, 0, 0, CT, 1, 0, 0, 0, 0);
		chk(16'(fields.table_mode), 16'h1, "table mode");
		end_sim();
	end
endmodule

// ===== bench/idt_prog_mem.sv
// Purpose: program memory model feeding one word per instruction cycle
// Assumes: the bench loads it while the core is held in reset
// Notes: condition and pc-change flags ride beside each word as two extra bits
`timescale 1ns/1ps
module idt_prog_mem (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        fetch_next_in,
	input  wire logic        load_in,
	input  wire logic [2:0]  load_addr_in,
	input  wire logic [17:0] load_data_in,
	output logic [15:0]      word_out,
	output logic             cond_true_out,
	output logic             pc_change_out
);
	logic [17:0] mem_r [8];
	logic [2:0]  pc_r;
	logic [2:0]  pc_nxt;

	// flush cycles still advance, so a skipped word is fetched and thrown away
	assign pc_nxt = fetch_next_in ? pc_r + 3'h1 : pc_r;

	always_ff @(posedge mclk_in) begin
		if (load_in) begin
			mem_r[load_addr_in] <= load_data_in;
		end
		pc_r <= rst_in ? 3'h0 : pc_nxt;
	end

	// whole word per location, held for four clocks from the second quarter of each instruction cycle
	assign {cond_true_out, pc_change_out, word_out} = mem_r[pc_r];
endmodule

// ===== rtl/idt_decode_top.sv
// Purpose: instruction decode and cycle timing for an 8-bit core
// Assumes: word_in is valid at the last quarter of each instruction cycle
// Notes: cond_true_in and pc_change_in are sampled with the first word
`timescale 1ns/1ps
module idt_decode_top (
	input  wire logic                 mclk_in,
	input  wire logic                 rst_in,
	input  wire logic [15:0]          word_in,
	input  wire logic                 cond_true_in,
	input  wire logic                 pc_change_in,
	output idt_pkg::idt_fields_t      fields_out,
	output idt_pkg::idt_move_t        move_out,
	output logic                      wr_working_out,
	output logic                      wr_file_out,
	output logic                      exec_nop_out,
	output logic                      fetch_next_out,
	output logic [1:0]                cycles_out,
	output logic                      instr_done_out,
	output logic [1:0]                quarter_out
);
	typedef enum logic [1:0] {
		IDT_ST_FIRST = 2'b00,
		IDT_ST_WORD2 = 2'b01,
		IDT_ST_WORD3 = 2'b11,
		IDT_ST_FLUSH = 2'b10
	} idt_state_t;

	idt_state_t           state_r, state_nxt;
	idt_pkg::idt_fields_t dec_w, fields_r;
	idt_pkg::idt_move_t   move_r, move_nxt;
	logic [1:0]           quarter_w, quarter_r, words_left_r, words_left_nxt;
	logic [1:0]           cyc_r, cyc_nxt, flush_r, flush_nxt;
	logic                 cyc_end_w, pend_branch_r, pend_branch_nxt;
	logic                 wr_w_r, wr_f_r, nop_r, fetch_r, done_r;
	logic [11:0]          first_src_r;

	idt_field_decode u_dec (
		.word_in    (word_in),
		.fields_out (dec_w)
	);
	idt_quarter_gen u_qgen (
		.mclk_in       (mclk_in),
		.rst_in        (rst_in),
		.quarter_out   (quarter_w),
		.cycle_end_out (cyc_end_w)
	);

	wire logic first_cyc = cyc_end_w && (state_r == IDT_ST_FIRST);
	wire logic multi     = dec_w.extra_words != 2'h0;
	wire logic taken1    = !multi && (cond_true_in || pc_change_in);
	// two-word branches pay one more cycle when taken
	wire logic taken2    = multi && dec_w.is_branch && pc_change_in;
	wire logic [1:0] base_cyc = multi ? idt_pkg::CYC_TWO :
		(taken1 ? idt_pkg::CYC_TWO : idt_pkg::CYC_ONE);
	wire logic [1:0] tot_cyc  = taken2 ? idt_pkg::CYC_THREE :
		(dec_w.extra_words == 2'h2) ? idt_pkg::CYC_THREE : base_cyc;
	// lone extension word decodes as nop
	wire logic alone_nop = dec_w.is_nop;
	wire logic [11:0] src_forced = {idt_pkg::BANK_FORCE, word_in[9:0]};
	wire logic [11:0] dst_forced = {idt_pkg::BANK_FORCE, word_in[9:0]};
	wire logic is_move_file_to_file_w = (dec_w.opcode == idt_pkg::OP_MOVE_FF) && multi;

	always_comb begin
		state_nxt       = state_r;
		words_left_nxt  = words_left_r;
		cyc_nxt         = cyc_r;
		flush_nxt       = flush_r;
		pend_branch_nxt = pend_branch_r;
		move_nxt        = move_r;
		move_nxt.valid  = 1'b0;
		if (cyc_end_w) begin
			unique case (state_r)
				IDT_ST_FIRST: begin
					cyc_nxt         = tot_cyc;
					pend_branch_nxt = taken2;
					if (multi) begin
						words_left_nxt = dec_w.extra_words;
						state_nxt      = IDT_ST_WORD2;
					end else if (taken1) begin
						flush_nxt = 2'h1;
						state_nxt = IDT_ST_FLUSH;
					end
				end
				IDT_ST_WORD2: begin
					// the second word supplies the destination of a file move
					if (is_move_file_to_file_w || fields_r.opcode == idt_pkg::OP_MOVE_FF) begin
						move_nxt.dst_addr = dst_forced;
						move_nxt.src_addr = first_src_r;
						move_nxt.valid    = 1'b1;
					end
					if (words_left_r == 2'h2) begin
						words_left_nxt = 2'h1;
						state_nxt      = IDT_ST_WORD3;
					end else if (pend_branch_r) begin
						flush_nxt = 2'h1;
						state_nxt = IDT_ST_FLUSH;
					end else begin
						state_nxt = IDT_ST_FIRST;
					end
				end
				IDT_ST_WORD3: begin
					words_left_nxt = 2'h0;
					state_nxt      = IDT_ST_FIRST;
				end
				IDT_ST_FLUSH: begin
					flush_nxt = 2'h0;
					state_nxt = IDT_ST_FIRST;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_r       <= IDT_ST_FIRST;
			words_left_r  <= 2'h0;
			cyc_r         <= 2'h0;
			flush_r       <= 2'h0;
			pend_branch_r <= 1'b0;
			move_r        <= '0;
		end else begin
			state_r       <= state_nxt;
			words_left_r  <= words_left_nxt;
			cyc_r         <= cyc_nxt;
			flush_r       <= flush_nxt;
			pend_branch_r <= pend_branch_nxt;
			move_r        <= move_nxt;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			fields_r    <= '0;
			first_src_r <= 12'h000;
		end else if (first_cyc) begin
			fields_r    <= dec_w;
			first_src_r <= src_forced;
		end
	end

	// result routing: only a non-nop byte op writes, d picks the target
	wire logic byte_op   = first_cyc && (dec_w.group == idt_pkg::IDT_GRP_BYTE) && !alone_nop;
	wire logic wr_w_nxt  = byte_op && !dec_w.dest_file;
	wire logic wr_f_nxt  = byte_op && dec_w.dest_file;
	wire logic nop_nxt   = cyc_end_w && ((state_r == IDT_ST_FLUSH) ||
		(state_r == IDT_ST_FIRST && alone_nop));
	wire logic done_nxt  = cyc_end_w && (state_nxt == IDT_ST_FIRST);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			wr_w_r    <= 1'b0;
			wr_f_r    <= 1'b0;
			nop_r     <= 1'b0;
			fetch_r   <= 1'b0;
			done_r    <= 1'b0;
			quarter_r <= idt_pkg::Q_RESET;
		end else begin
			wr_w_r    <= wr_w_nxt;
			wr_f_r    <= wr_f_nxt;
			nop_r     <= nop_nxt;
			fetch_r   <= cyc_end_w;
			done_r    <= done_nxt;
			quarter_r <= quarter_w;
		end
	end

	assign fields_out     = fields_r;
	assign move_out       = move_r;
	assign wr_working_out = wr_w_r;
	assign wr_file_out    = wr_f_r;
	assign exec_nop_out   = nop_r;
	assign fetch_next_out = fetch_r;
	assign cycles_out     = cyc_r;
	assign instr_done_out = done_r;
	assign quarter_out    = quarter_r;

	sequence two_cycle_s;
		(cyc_r == idt_pkg::CYC_TWO) ##4 done_r;
	endsequence
	word_nop_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(first_cyc && word_in[15:12] == idt_pkg::EXT_PREFIX && dec_w.is_nop)
		|=> nop_r && !wr_w_r && !wr_f_r)
		else $error("lone extension word not run as nop");
	dest_route_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		byte_op |=> (wr_w_r != wr_f_r) && (wr_f_r == fields_r.dest_file))
		else $error("byte result routed wrongly");
	single_cyc_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(first_cyc && !multi && !taken1) |=> cyc_r == idt_pkg::CYC_ONE && done_r)
		else $error("plain single word not one cycle");
	taken_two_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(first_cyc && taken1) |=> state_r == IDT_ST_FLUSH ##4 nop_r)
		else $error("taken single word lacks nop cycle");
	double_word_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(first_cyc && dec_w.extra_words == 2'h1 && !taken2) |=> two_cycle_s)
		else $error("double word not two cycles");
	branch_three_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(first_cyc && taken2) |=> (cyc_r == idt_pkg::CYC_THREE) ##4 !done_r ##4 done_r)
		else $error("taken two word branch not three cycles");
	bank_force_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		move_r.valid |-> move_r.src_addr[11:10] == idt_pkg::BANK_FORCE &&
		move_r.dst_addr[11:10] == idt_pkg::BANK_FORCE)
		else $error("file move bank bits not forced");
	fetch_pace_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		fetch_r |-> ##4 fetch_r)
		else $error("fetch not every four periods");
	group_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_r != IDT_ST_FIRST) |=> $stable(fields_r))
		else $error("fields changed inside multi word");
endmodule

// ===== rtl/idt_field_decode.sv
// Purpose: combinational split of one 16-bit word into group and operand fields
// Assumes: word is the first word of an instruction
// Notes: extra-word counts drive the sequencer in the top module
`timescale 1ns/1ps
module idt_field_decode (
	input  wire logic [15:0]          word_in,
	output idt_pkg::idt_fields_t      fields_out
);
	wire logic [3:0] top4     = word_in[15:12];
	wire logic [7:0] top8     = word_in[15:8];
	wire logic       is_ext   = (top4 == idt_pkg::EXT_PREFIX) &&
		(top8 != idt_pkg::OP_CALL_LO) && (top8 != idt_pkg::OP_CALL_HI) &&
		(top8 != idt_pkg::OP_LFSR) && (top8 != idt_pkg::OP_GOTO);
	wire logic       is_bitop = (top4 >= 4'h7) && (top4 <= 4'hb);
	wire logic       is_move_file_to_file = (top4 == idt_pkg::OP_MOVE_FF);
	wire logic       is_ffl   = (word_in[15:4] == idt_pkg::OP_MOVE_FFL[15:4]);
	wire logic       is_two   = is_move_file_to_file || (top8 == idt_pkg::OP_LFSR) ||
		(top8 == idt_pkg::OP_CALL_LO) || (top8 == idt_pkg::OP_CALL_HI) ||
		(top8 == idt_pkg::OP_GOTO);
	// literal ops: 0x08..0x0f top byte, bank-select 0x01, and the pointer load
	wire logic       is_lit   = (top8 == idt_pkg::OP_LFSR) ||
		((top4 == 4'h0) && word_in[11]) || (top8 == 8'h01);
	wire logic       is_ctl   = (top4 == 4'hd) || (top4 == 4'he) || (top8 == idt_pkg::OP_CALL_LO)
		|| (top8 == idt_pkg::OP_CALL_HI) || (top8 == idt_pkg::OP_GOTO)
		|| (top8 == 8'h00 && !is_ffl);
	wire idt_pkg::idt_group_t grp = is_bitop ? idt_pkg::IDT_GRP_BIT :
		is_lit ? idt_pkg::IDT_GRP_LIT : is_ctl ? idt_pkg::IDT_GRP_CTL : idt_pkg::IDT_GRP_BYTE;

	always_comb begin
		fields_out             = '0;
		fields_out.group       = grp;
		fields_out.opcode      = top4;
		fields_out.file_addr   = word_in[7:0];
		fields_out.dest_file   = (grp == idt_pkg::IDT_GRP_BYTE) && word_in[9];
		fields_out.access_bank = word_in[8];
		fields_out.bit_num     = is_bitop ? word_in[11:9] : 3'h0;
		fields_out.literal     = (grp == idt_pkg::IDT_GRP_LIT) ? word_in[7:0] : 8'h00;
		fields_out.ptr_sel     = (top8 == idt_pkg::OP_LFSR) ? word_in[5:4] : 2'h0;
		fields_out.prog_addr   = (grp == idt_pkg::IDT_GRP_CTL) ? word_in[10:0] : 11'h000;
		fields_out.fast_mode   = (top8 == idt_pkg::OP_CALL_HI) && word_in[8];
		fields_out.table_mode  = (top8 == 8'h00 && word_in[7:3] == 5'h01) ? word_in[1:0] : 2'h0;
		fields_out.is_nop      = is_ext || (word_in == idt_pkg::NOP_WORD);
		fields_out.extra_words = is_ffl ? 2'h2 : is_two ? 2'h1 : 2'h0;
		fields_out.is_branch   = (top4 == 4'hd) || (top8 == idt_pkg::OP_CALL_LO) ||
			(top8 == idt_pkg::OP_CALL_HI) || (top8 == idt_pkg::OP_GOTO);
		fields_out.is_skip     = (top4 == 4'hb) || (top4 == 4'ha) ||
			(top8[7:2] == 6'h18 && word_in[9:8] != 2'h3) || (top8[7:2] == 6'h0b);
	end
endmodule

// ===== rtl/idt_pkg.sv
// Purpose: shared constants and types for the instruction decode and timing block
// Assumes: 16-bit program words, one instruction cycle of four clock periods
// Notes: encodings follow the standard 8-bit core opcode map
package idt_pkg;
	localparam int          WORD_W        = 16;
	localparam int          QUARTERS      = 4;
	localparam logic [1:0]  Q_LAST        = 2'h3;
	localparam logic [1:0]  Q_RESET       = 2'h0;
	localparam logic [3:0]  EXT_PREFIX    = 4'hf;
	localparam logic [3:0]  OP_MOVE_FF    = 4'hc;
	localparam logic [15:0] OP_MOVE_FFL   = 16'h0060;
	localparam logic [7:0]  OP_LFSR       = 8'hee;
	localparam logic [7:0]  OP_CALL_LO    = 8'hec;
	localparam logic [7:0]  OP_CALL_HI    = 8'hed;
	localparam logic [7:0]  OP_GOTO       = 8'hef;
	localparam logic [1:0]  BANK_FORCE    = 2'h0;
	localparam logic [15:0] NOP_WORD      = 16'h0000;
	localparam logic [1:0]  CYC_ONE       = 2'h1;
	localparam logic [1:0]  CYC_TWO       = 2'h2;
	localparam logic [1:0]  CYC_THREE     = 2'h3;

	typedef enum logic [1:0] {
		IDT_GRP_BYTE = 2'h0,
		IDT_GRP_BIT  = 2'h1,
		IDT_GRP_LIT  = 2'h2,
		IDT_GRP_CTL  = 2'h3
	} idt_group_t;

	typedef struct packed {
		idt_group_t  group;
		logic [3:0]  opcode;
		logic [7:0]  file_addr;
		logic        dest_file;
		logic        access_bank;
		logic [2:0]  bit_num;
		logic [7:0]  literal;
		logic [1:0]  ptr_sel;
		logic [10:0] prog_addr;
		logic        fast_mode;
		logic [1:0]  table_mode;
		logic        is_nop;
		logic [1:0]  extra_words;
		logic        is_branch;
		logic        is_skip;
	} idt_fields_t;

	typedef struct packed {
		logic [11:0] src_addr;
		logic [11:0] dst_addr;
		logic        valid;
	} idt_move_t;
endpackage

// ===== rtl/idt_quarter_gen.sv
// Purpose: divides the clock into four quarter periods per instruction cycle
// Assumes: synchronous active-high reset
// Notes: cycle_end pulses in the last quarter
`timescale 1ns/1ps
module idt_quarter_gen (
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	output logic [1:0]      quarter_out,
	output logic            cycle_end_out
);
	logic [1:0] quarter_r;
	assign quarter_out   = quarter_r;
	assign cycle_end_out = (quarter_r == idt_pkg::Q_LAST);
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			quarter_r <= idt_pkg::Q_RESET;
		end else begin
			quarter_r <= quarter_r + 2'h1;
		end
	end
	quarter_wrap_a: assert property (@(posedge mclk_in) disable iff (rst_in)
		(quarter_r == idt_pkg::Q_LAST) |=> (quarter_r == idt_pkg::Q_RESET))
		else $error("quarter counter did not wrap after four periods");
endmodule
